// [limit_compare_status_pkg.sv]
package limit_compare_status_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CONFIG       = 8'h40;
    localparam logic [7:0] IDX_STATUS_ONE   = 8'h41;
    localparam logic [7:0] IDX_STATUS_TWO   = 8'h42;
    localparam logic [7:0] IDX_RAIL25_LOW   = 8'h44;
    localparam logic [7:0] IDX_RAIL25_HIGH  = 8'h45;
    localparam logic [7:0] IDX_SUPPLY_LOW   = 8'h48;
    localparam logic [7:0] IDX_SUPPLY_HIGH  = 8'h49;
    localparam logic [7:0] IDX_REM_A_LOW    = 8'h4E;
    localparam logic [7:0] IDX_REM_A_HIGH   = 8'h4F;
    localparam logic [7:0] IDX_LOCAL_LOW    = 8'h50;
    localparam logic [7:0] IDX_LOCAL_HIGH   = 8'h51;
    localparam logic [7:0] IDX_REM_B_LOW    = 8'h52;
    localparam logic [7:0] IDX_REM_B_HIGH   = 8'h53;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h80;
    localparam logic [7:0] IDX_IRQ_MASK     = 8'h81;

    localparam int ADDR_W = 10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_START_BIT   = 0;
    localparam int CFG_LOCK_BIT    = 1;
    localparam int CFG_TIMER_BIT   = 2;
    localparam int S1_RAIL25_BIT   = 0;
    localparam int S1_SUPPLY_BIT   = 2;
    localparam int S1_TEMP_BIT     = 4;
    localparam int S1_SUMMARY_BIT  = 7;
    localparam int S2_OVERTEMP_BIT = 1;
    localparam int S2_FAN_BIT      = 2;
    localparam int S2_FAN4_BIT     = 5;
    localparam int S2_DIODE_BIT    = 6;

    // ------------------------------------------------------------
    // Reset values and used status bit masks
    // ------------------------------------------------------------
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [7:0]  CONFIG_RESET    = 8'h00;
    localparam logic [7:0]  VOLT_LOW_RESET  = 8'h00;
    localparam logic [7:0]  VOLT_HIGH_RESET = 8'hFF;
    localparam logic [7:0]  TEMP_LOW_RESET  = 8'h81;
    localparam logic [7:0]  TEMP_HIGH_RESET = 8'h7F;
    localparam logic [15:0] IRQ_RESET       = 16'h0000;
    localparam logic [7:0]  S1_USED_MASK    = 8'hF5;
    localparam logic [7:0]  S2_USED_MASK    = 8'hFE;

    // Low and high limit of one channel
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } limit_pair_s;

    // Channel slots: 0 rail25, 1 supply, 2..4 remote a, local, remote b
    localparam int NUM_CH   = 5;
    localparam int NUM_TEMP = 3;

    localparam limit_pair_s VOLT_DEFAULT = '{high: VOLT_HIGH_RESET, low: VOLT_LOW_RESET};
    localparam limit_pair_s TEMP_DEFAULT = '{high: TEMP_HIGH_RESET, low: TEMP_LOW_RESET};

endpackage

// [limit_compare_status.sv]
`timescale 1ns/10ps
// Behaviour
// RL1: Status one bit 0 sets when the 2.5 V reading breaks its limits.
// RL2: Status one bit 2 sets when the supply reading breaks its limits.
// RL3: Status one bits 4, 5, 6 set for remote a, local, remote b temperature.
// RL4: Reading status one clears each flag only if its fault has gone.
// RL5: Status one bit 7 is the OR of all status two bits.
// RL6: Status two bit 1 sets when any overtemperature limit is exceeded.
// RL7: Reading status two clears bit 1 only below limit minus hysteresis.
// RL8: Status two bits 2, 3, 4 set on failure of fans one to three.
// RL9: Fan failure flags are suppressed while their pulse output is off.
// RL10: Status two bit 5 sets when fan four fails.
// RL11: In timer mode bit 5 instead sets when assertion time exceeds limit.
// RL12: Status two bits 6, 7 set on diode a or b open or short.
// RL13: Temperature flag sets one degree above high limit, at or below low; defaults 0x81 and 0x7F.
// RL14: Voltage and temperature limits stay writable after the lock bit.
// RL15: Status registers reset to zero; voltage limits reset 0x00 and 0xFF.
// RL16: High violation is strictly above; low violation is at or below.
// RL17: Programmed limits apply only with start bit set, else defaults.
// RL18: Reserved status bits read zero and are never set.
module limit_compare_status
    import limit_compare_status_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic [7:0]        rail25_value,
    input  wire logic [7:0]        supply_value,
    input  wire logic [7:0]        remote_a_temp,
    input  wire logic [7:0]        local_temp,
    input  wire logic [7:0]        remote_b_temp,
    input  wire logic              overtemp_above,
    input  wire logic              overtemp_below_hyst,
    input  wire logic [3:0]        fan_slow,
    input  wire logic [2:0]        pwm_off,
    input  wire logic              thermal_alarm_pin_time_over,
    input  wire logic [1:0]        diode_fault
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Unsigned window test
    function automatic logic out_unsigned(input logic [7:0] v, input limit_pair_s l);
        out_unsigned = (v > l.high) || (v <= l.low); // RL16
    endfunction

    // Two's complement window test
    function automatic logic out_signed(input logic [7:0] v, input limit_pair_s l);
        out_signed = ($signed(v) > $signed(l.high)) || ($signed(v) <= $signed(l.low)); // RL16 RL13
    endfunction

    // Keep flag on a read only while its fault persists; set beats clear
    function automatic logic [7:0] next_flags(input logic [7:0] cur, input logic [7:0] cond,
                                              input logic rd);
        next_flags = rd ? (cur & cond) | cond : cur | cond;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    limit_pair_s       lim_reg [NUM_CH];
    logic [7:0]        config_reg;
    logic [7:0]        status_one_reg;
    logic [7:0]        status_two_reg;
    logic [15:0]       irq_status_reg;
    logic [15:0]       irq_mask_reg;
    logic              pready_reg;
    logic [31:0]       prdata_reg;
    logic              pslverr_reg;
    logic              irq_reg;

    logic [7:0]        idx;
    logic              aligned;
    logic              rd_capture;
    logic              wr_commit;
    logic              rd_one;
    logic              rd_two;
    logic [7:0]        cond_one;
    logic [7:0]        cond_two;
    logic [7:0]        one_next;
    logic [7:0]        two_next;
    logic [NUM_CH-1:0] ch_out;
    limit_pair_s       lim_use [NUM_CH];
    logic [31:0]       rd_data;
    logic              rd_err;
    logic [15:0]       irq_rise;
    logic [15:0]       irq_clr;

    assign idx        = paddr[9:2];
    assign aligned    = (paddr[1:0] == 2'b00);
    assign rd_capture = psel && penable && !pwrite && !pready_reg;
    assign wr_commit  = psel && penable && pwrite && pready_reg;
    assign rd_one     = rd_capture && aligned && (idx == IDX_STATUS_ONE); // RL4
    assign rd_two     = rd_capture && aligned && (idx == IDX_STATUS_TWO); // RL7

    // ------------------------------------------------------------
    // Limit comparison
    // ------------------------------------------------------------
    // Defaults stand in while monitoring is stopped
    assign lim_use[0] = config_reg[CFG_START_BIT] ? lim_reg[0] : VOLT_DEFAULT; // RL17
    assign lim_use[1] = config_reg[CFG_START_BIT] ? lim_reg[1] : VOLT_DEFAULT; // RL17
    assign ch_out[0]  = out_unsigned(rail25_value, lim_use[0]);
    assign ch_out[1]  = out_unsigned(supply_value, lim_use[1]);

    // Temperature channels
    generate
        for (genvar t = 0; t < NUM_TEMP; t++) begin : g_temp
            logic [7:0] tval;
            assign tval = (t == 0) ? remote_a_temp : (t == 1) ? local_temp : remote_b_temp;
            assign lim_use[t+2] = config_reg[CFG_START_BIT] ? lim_reg[t+2] : TEMP_DEFAULT; // RL17
            assign ch_out[t+2]  = out_signed(tval, lim_use[t+2]); // RL13
        end
    endgenerate

    // Live fault conditions for each status bit
    always_comb begin
        cond_one = 8'h00;
        cond_one[S1_RAIL25_BIT] = ch_out[0]; // RL1
        cond_one[S1_SUPPLY_BIT] = ch_out[1]; // RL2
        cond_one[S1_TEMP_BIT +: NUM_TEMP] = ch_out[NUM_CH-1:2]; // RL3
        cond_two = 8'h00;
        cond_two[S2_OVERTEMP_BIT] = overtemp_above; // RL6
        cond_two[S2_FAN_BIT +: 3] = fan_slow[2:0] & ~pwm_off; // RL8 RL9
        cond_two[S2_FAN4_BIT] = config_reg[CFG_TIMER_BIT] ? thermal_alarm_pin_time_over // RL11
                                                           : fan_slow[3] & ~pwm_off[2]; // RL10 RL9
        cond_two[S2_DIODE_BIT +: 2] = diode_fault; // RL12
    end

    // Next values of both status registers
    always_comb begin
        one_next = next_flags(status_one_reg, cond_one, rd_one) & S1_USED_MASK; // RL4 RL18
        one_next[S1_SUMMARY_BIT] = 1'b0;
        two_next = next_flags(status_two_reg, cond_two, rd_two) & S2_USED_MASK; // RL18
        // Overtemperature leaves only once below the hysteresis point
        if (rd_two && status_two_reg[S2_OVERTEMP_BIT] && !overtemp_below_hyst) begin
            two_next[S2_OVERTEMP_BIT] = 1'b1; // RL7
        end
    end

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    // Latched fault flags
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status_one_reg <= STATUS_RESET; // RL15
            status_two_reg <= STATUS_RESET; // RL15
        end else begin
            status_one_reg <= one_next;
            status_two_reg <= two_next;
        end
    end

    // ------------------------------------------------------------
    // Limit and configuration registers
    // ------------------------------------------------------------
    // Limits ignore the lock bit
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lim_reg[0] <= VOLT_DEFAULT; // RL15
            lim_reg[1] <= VOLT_DEFAULT; // RL15
            lim_reg[2] <= TEMP_DEFAULT; // RL13
            lim_reg[3] <= TEMP_DEFAULT;
            lim_reg[4] <= TEMP_DEFAULT;
        end else if (wr_commit && aligned && pstrb[0]) begin // RL14
            if (idx == IDX_RAIL25_LOW) begin
                lim_reg[0].low <= pwdata[7:0];
            end else if (idx == IDX_RAIL25_HIGH) begin
                lim_reg[0].high <= pwdata[7:0];
            end else if (idx == IDX_SUPPLY_LOW) begin
                lim_reg[1].low <= pwdata[7:0];
            end else if (idx == IDX_SUPPLY_HIGH) begin
                lim_reg[1].high <= pwdata[7:0];
            end else if (idx == IDX_REM_A_LOW) begin
                lim_reg[2].low <= pwdata[7:0];
            end else if (idx == IDX_REM_A_HIGH) begin
                lim_reg[2].high <= pwdata[7:0];
            end else if (idx == IDX_LOCAL_LOW) begin
                lim_reg[3].low <= pwdata[7:0];
            end else if (idx == IDX_LOCAL_HIGH) begin
                lim_reg[3].high <= pwdata[7:0];
            end else if (idx == IDX_REM_B_LOW) begin
                lim_reg[4].low <= pwdata[7:0];
            end else if (idx == IDX_REM_B_HIGH) begin
                lim_reg[4].high <= pwdata[7:0];
            end
        end
    end

    // Start bit freezes once lock is written; lock itself is write-once
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            config_reg <= CONFIG_RESET;
        end else if (wr_commit && aligned && pstrb[0] && idx == IDX_CONFIG) begin
            if (!config_reg[CFG_LOCK_BIT]) begin
                config_reg[CFG_START_BIT] <= pwdata[CFG_START_BIT];
                config_reg[CFG_LOCK_BIT]  <= pwdata[CFG_LOCK_BIT];
            end
            config_reg[CFG_TIMER_BIT] <= pwdata[CFG_TIMER_BIT];
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    // Rising flags and write-one clears of the sticky bits
    always_comb begin
        irq_rise = {two_next & ~status_two_reg, one_next & ~status_one_reg};
        irq_clr  = 16'h0000;
        if (wr_commit && aligned && idx == IDX_IRQ_STATUS) begin
            irq_clr = pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}};
        end
    end

    // Sticky interrupt bits; a new set beats a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_status_reg <= IRQ_RESET;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_rise;
        end
    end

    // Interrupt enable mask
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_mask_reg <= IRQ_RESET;
        end else if (wr_commit && aligned && idx == IDX_IRQ_MASK) begin
            if (pstrb[0]) begin
                irq_mask_reg[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                irq_mask_reg[15:8] <= pwdata[15:8];
            end
        end
    end

    // Level interrupt output
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Read mux and unmapped detection
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (!aligned) begin
            rd_err = 1'b1;
        end else if (idx == IDX_CONFIG) begin
            rd_data[7:0] = config_reg;
        end else if (idx == IDX_STATUS_ONE) begin
            rd_data[7:0] = status_one_reg;
            rd_data[S1_SUMMARY_BIT] = |status_two_reg; // RL5
        end else if (idx == IDX_STATUS_TWO) begin
            rd_data[7:0] = status_two_reg;
        end else if (idx == IDX_RAIL25_LOW) begin
            rd_data[7:0] = lim_reg[0].low;
        end else if (idx == IDX_RAIL25_HIGH) begin
            rd_data[7:0] = lim_reg[0].high;
        end else if (idx == IDX_SUPPLY_LOW) begin
            rd_data[7:0] = lim_reg[1].low;
        end else if (idx == IDX_SUPPLY_HIGH) begin
            rd_data[7:0] = lim_reg[1].high;
        end else if (idx == IDX_REM_A_LOW) begin
            rd_data[7:0] = lim_reg[2].low;
        end else if (idx == IDX_REM_A_HIGH) begin
            rd_data[7:0] = lim_reg[2].high;
        end else if (idx == IDX_LOCAL_LOW) begin
            rd_data[7:0] = lim_reg[3].low;
        end else if (idx == IDX_LOCAL_HIGH) begin
            rd_data[7:0] = lim_reg[3].high;
        end else if (idx == IDX_REM_B_LOW) begin
            rd_data[7:0] = lim_reg[4].low;
        end else if (idx == IDX_REM_B_HIGH) begin
            rd_data[7:0] = lim_reg[4].high;
        end else if (idx == IDX_IRQ_STATUS) begin
            rd_data[15:0] = irq_status_reg;
        end else if (idx == IDX_IRQ_MASK) begin
            rd_data[15:0] = irq_mask_reg;
        end else begin
            rd_err = 1'b1;
        end
    end

    // One wait state, then a registered answer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (psel && penable && !pready_reg) begin
            pready_reg  <= 1'b1;
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr_reg <= rd_err;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    assign pready  = pready_reg;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;
    assign irq     = irq_reg;

endmodule // limit_compare_status

// [limit_compare_status_assertions.sv]
`timescale 1ns/10ps
module limit_compare_status_checker
    import limit_compare_status_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              irq,
    input wire logic              overtemp_above,
    input wire logic [1:0]        diode_fault
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Completed status reads
    // ------------------------------------------------------------
    wire logic rd_s1 = pready && !pwrite && !pslverr && paddr[9:2] == IDX_STATUS_ONE;
    wire logic rd_s2 = pready && !pwrite && !pslverr && paddr[9:2] == IDX_STATUS_TWO;

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_PREADY_WAIT: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("pready missing in second access cycle");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_PREADY_CAUSE: assert property (pready |-> $past(psel && penable))
        else $error("pready without access phase");
    AST_WRITE_DATA: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on write");
    AST_S1_RESERVED: assert property (rd_s1 |-> prdata[3] == 1'b0 && prdata[1] == 1'b0
        && prdata[31:8] == 24'h0)
        else $error("reserved status one bit set");
    AST_S2_RESERVED: assert property (rd_s2 |-> prdata[0] == 1'b0
        && prdata[31:8] == 24'h0)
        else $error("reserved status two bit set");
    AST_S2_OVERTEMP: assert property (rd_s2 && $past(overtemp_above, 2)
        && $past(overtemp_above, 3) |-> prdata[1])
        else $error("overtemp flag missing");
    AST_S2_DIODE: assert property (rd_s2 |->
        (prdata[7:6] & $past(diode_fault, 2) & $past(diode_fault, 3))
        == ($past(diode_fault, 2) & $past(diode_fault, 3)))
        else $error("diode fault flag missing");
    AST_MASK_OFF: assert property (pready && pwrite && paddr[9:2] == IDX_IRQ_MASK
        && pwdata[15:0] == 16'h0 |-> ##[1:2] !irq)
        else $error("irq stays with mask cleared");

    // Main scenarios reached
    cover property (rd_s2 && prdata[1]);
    cover property (pready && pslverr);
    cover property ($rose(irq));
endmodule // limit_compare_status_checker

bind limit_compare_status limit_compare_status_checker i_chk (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq(irq), .overtemp_above(overtemp_above), .diode_fault(diode_fault)
);

// [limit_compare_status_bench.sv]
`timescale 1ns/10ps
module limit_compare_status_bench import limit_compare_status_pkg::*;;
    logic              clk_sys, rstn, psel, penable, pwrite, pready, pslverr, irq;
    logic              overtemp_above, overtemp_below_hyst, thermal_alarm_pin_time_over;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, lfsr;
    logic [3:0]        pstrb, fan_slow;
    logic [2:0]        pwm_off;
    logic [1:0]        diode_fault;
    logic [7:0]        vals [5];
    logic [32:0]       exp_q [$];
    int                err_count, checked;
    logic [7:0] ridx [15] = '{IDX_STATUS_ONE, IDX_STATUS_TWO, IDX_RAIL25_LOW, IDX_RAIL25_HIGH,
        IDX_SUPPLY_LOW, IDX_SUPPLY_HIGH, IDX_REM_A_LOW, IDX_REM_A_HIGH, IDX_LOCAL_LOW,
        IDX_LOCAL_HIGH, IDX_REM_B_LOW, IDX_REM_B_HIGH, IDX_CONFIG, IDX_IRQ_STATUS, IDX_IRQ_MASK};
    logic [7:0] rexp [15] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h81, 8'h7F, 8'h81,
        8'h7F, 8'h81, 8'h7F, 8'h00, 8'h00, 8'h00};
    logic [7:0] cbit [5] = '{8'h01, 8'h04, 8'h10, 8'h20, 8'h40};

    limit_compare_status i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .rail25_value(vals[0]), .supply_value(vals[1]),
        .remote_a_temp(vals[2]), .local_temp(vals[3]), .remote_b_temp(vals[4]),
        .overtemp_above(overtemp_above), .overtemp_below_hyst(overtemp_below_hyst),
        .fan_slow(fan_slow), .pwm_off(pwm_off), .thermal_alarm_pin_time_over(thermal_alarm_pin_time_over),
        .diode_fault(diode_fault));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] expv);
        checked++;
        if (seen !== expv) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic report_and_stop;
        // An answer that never came leaves its note behind
        if (exp_q.size() != 0) begin
            err_count++;
        end
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Bus cycle: setup, access until pready, release, one idle edge
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        input logic [32:0] expv);
        exp_q.push_back(expv);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // pready ends this wait; if it never comes, the watchdog does
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        xfer(1'b0, idx, 32'h0, {1'b0, e});
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d, 33'h0);
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_sys);
    endtask

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Response monitor against noted expectations
    always @(posedge clk_sys) begin
        if (rstn && pready === 1'b1) begin
            if (exp_q.size() == 0) check({pslverr, prdata}, 33'h1FFFFFFFF);
            else check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // Watchdog
    initial begin
        #50000;
        $display("watchdog expired");
        err_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        pstrb = 4'hF; vals = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h40}; lfsr = 32'h608C;
        overtemp_above = 1'b0; overtemp_below_hyst = 1'b1; thermal_alarm_pin_time_over = 1'b0;
        fan_slow = 4'h0; pwm_off = 3'h0; diode_fault = 2'h0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 15; i++) rd(ridx[i], {24'h0, rexp[i]});
        xfer(1'b0, 8'h43, 32'h0, {1'b1, 32'h0});
        $display("power-on values done");
        wr(IDX_IRQ_MASK, 32'hFFFF);
        wr(IDX_RAIL25_HIGH, 32'h30);
        settle();
        rd(IDX_STATUS_ONE, 32'h00);
        wr(IDX_CONFIG, 32'h03);
        settle();
        rd(IDX_STATUS_ONE, 32'h01);
        for (int i = 2; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(ridx[i], {24'h0, 1'b0, i[0], lfsr[5:0]});
            rd(ridx[i], {24'h0, 1'b0, i[0], lfsr[5:0]});
        end
        rd(IDX_STATUS_ONE, 32'h01);
        rd(IDX_STATUS_ONE, 32'h00);
        $display("start and lock done");
        for (int c = 0; c < 5; c++) begin
            wr(ridx[2 + 2 * c], 32'h10);
            wr(ridx[3 + 2 * c], 32'h60);
            vals[c] <= 8'h61;
            settle();
            vals[c] <= 8'h60;
            settle();
            rd(IDX_STATUS_ONE, {24'h0, cbit[c]});
            rd(IDX_STATUS_ONE, 32'h00);
            vals[c] <= 8'h10;
            settle();
            vals[c] <= 8'h11;
            settle();
            rd(IDX_STATUS_ONE, {24'h0, cbit[c]});
            rd(IDX_STATUS_ONE, 32'h00);
        end
        $display("limit compare done");
        check({32'h0, irq}, 33'h1);
        rd(IDX_IRQ_STATUS, 32'h75);
        wr(IDX_IRQ_MASK, 32'h0);
        @(posedge clk_sys);
        check({32'h0, irq}, 33'h0);
        wr(IDX_IRQ_MASK, 32'hFFFF);
        wr(IDX_IRQ_STATUS, 32'hFFFF);
        @(posedge clk_sys);
        check({32'h0, irq}, 33'h0);
        rd(IDX_IRQ_STATUS, 32'h0);
        $display("interrupt done");
        overtemp_above <= 1'b1; overtemp_below_hyst <= 1'b0; fan_slow <= 4'hF; diode_fault <= 2'h3;
        settle();
        rd(IDX_STATUS_ONE, 32'h80);
        rd(IDX_STATUS_TWO, 32'hFE);
        overtemp_above <= 1'b0; fan_slow <= 4'h0; diode_fault <= 2'h0;
        settle();
        rd(IDX_STATUS_TWO, 32'hFE);
        rd(IDX_STATUS_TWO, 32'h02);
        overtemp_below_hyst <= 1'b1;
        settle();
        rd(IDX_STATUS_ONE, 32'h80);
        rd(IDX_STATUS_TWO, 32'h02);
        rd(IDX_STATUS_TWO, 32'h00);
        rd(IDX_STATUS_ONE, 32'h00);
        pwm_off <= 3'h4; fan_slow <= 4'hF;
        settle();
        rd(IDX_STATUS_TWO, 32'h0C);
        wr(IDX_CONFIG, 32'h07);
        pwm_off <= 3'h0; fan_slow <= 4'h7; thermal_alarm_pin_time_over <= 1'b1;
        settle();
        fan_slow <= 4'h0; thermal_alarm_pin_time_over <= 1'b0;
        settle();
        rd(IDX_STATUS_TWO, 32'h3C);
        rd(IDX_STATUS_TWO, 32'h00);
        $display("status two done");
        report_and_stop();
    end
endmodule // limit_compare_status_bench
